// ==== sif_top.v ====
// serial unit input conditioning, input routing, unit gating and channel stop
`include "sif_map.vh"
module sif_top #(
   parameter NCH = 2 // number of channels
) (
   // clock, reset, enable
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // wishbone classic slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [21:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // receive pin and its routes
   input wire async_receive_pin_i,
   input wire external_interrupt_input_i,
   input wire timer_ch1_input_pin_i,
   output wire rx_data_o,
   output reg extint_o,
   output reg timer_in_o,
   // unit clock gate and channel view
   output wire unit_clk_en_o,
   input wire [NCH-1:0] engine_data_i,
   input wire [NCH-1:0] engine_clk_i,
   output wire [NCH-1:0] channel_run_o,
   output wire [NCH-1:0] port_release_o,
   output reg [NCH-1:0] serial_data_o,
   output reg [NCH-1:0] serial_clk_o
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] rx_noise_filter_enable; // filter enable
   reg [7:0] input_switch_control; // receive routing
   reg [7:0] peripheral_clock_gate; // unit clock gate
   reg [NCH-1:0] channel_active_status; // per-channel running
   reg [NCH-1:0] serial_output_enable; // per-channel output enable
   reg [NCH-1:0] data_output_buffer; // data pin levels
   reg [NCH-1:0] clock_output_buffer; // clock pin levels
   wire rx_filtered; // conditioned receive level
   wire wr; // write strobe on byte lane 0
   wire rd_hit; // every address, mapped or not (tied high)
   wire unit_on; // unit clock enable bit
   reg [31:0] next_dat; // read mux

   assign unit_on = peripheral_clock_gate[`SIF_CLK_ON_BIT];
   assign unit_clk_en_o = unit_on;
   assign wr = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
   assign channel_run_o = channel_active_status & {NCH{unit_on}};
   assign port_release_o = ~channel_active_status & data_output_buffer
                           & clock_output_buffer;
   assign rx_data_o = rx_filtered;

   // ----------------------------------------
   // receive filter
   // ----------------------------------------
   sif_rx_filter u_filt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .filt_on_i(rx_noise_filter_enable[`SIF_FILT_ON_BIT]),
      .rx_i(async_receive_pin_i),
      .rx_o(rx_filtered)
   );

   // ----------------------------------------
   // input routing, registered outputs
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         extint_o <= 1'b1;
         timer_in_o <= 1'b1;
      end else if (ce_i) begin
         // receive replaces the interrupt pin when selected
         extint_o <= input_switch_control[`SIF_EXTINT_BIT] ? rx_filtered
                     : external_interrupt_input_i;
         timer_in_o <= input_switch_control[`SIF_TIMER_BIT] ? rx_filtered
                       : timer_ch1_input_pin_i;
      end
   end

   // ----------------------------------------
   // exempt registers: writable whatever the gate
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_noise_filter_enable <= `SIF_NFEN_RST;
         input_switch_control <= `SIF_ISC_RST;
         peripheral_clock_gate <= `SIF_PCG_RST;
      end else if (ce_i && wr) begin
         case (adr_i)
            // only bit 0 stored (bits 1:0 for input switch), others read zero
            `SIF_NFEN_ADDR: rx_noise_filter_enable <= {7'h00, dat_i[0]};
            `SIF_ISC_ADDR: input_switch_control <= {6'h00, dat_i[1:0]};
            `SIF_PCG_ADDR: peripheral_clock_gate <= {7'h00, dat_i[0]};
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // unit control registers, held at default while gated
   // ----------------------------------------
   // a start register is provided so the stop path can be exercised
   always @(posedge clk_i) begin
      if (rst_i || (ce_i && !unit_on)) begin
         channel_active_status <= `SIF_STAT_RST;
         serial_output_enable <= `SIF_OE_RST;
         // buffers are reset in their own per-bit process, one driver each
      end else if (ce_i) begin
         if (wr) begin
            case (adr_i)
               `SIF_START_ADDR: channel_active_status <= channel_active_status
                                | dat_i[NCH-1:0];
               // stop trigger: clear wins, nothing stored
               `SIF_STOP_ADDR: channel_active_status <= channel_active_status
                               & ~dat_i[NCH-1:0];
               `SIF_OE_ADDR: serial_output_enable <= dat_i[NCH-1:0];
               default: begin
               end
            endcase
         end
         // stat address absent from writes: read-only
      end
   end

   // per-bit buffers: clock from software only when the channel is idle, data only when its output enable is clear, else the engine
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_buf
         always @(posedge clk_i) begin
            if (rst_i || (ce_i && !unit_on)) begin
               // idle level high on both pins
               clock_output_buffer[g] <= 1'b1;
               data_output_buffer[g] <= 1'b1;
            end else if (ce_i) begin
               if (channel_active_status[g]) begin
                  clock_output_buffer[g] <= engine_clk_i[g];
               end else if (wr && adr_i == `SIF_CKOUT_ADDR) begin
                  clock_output_buffer[g] <= dat_i[g];
               end
               if (serial_output_enable[g]) begin
                  data_output_buffer[g] <= engine_data_i[g];
               end else if (wr && adr_i == `SIF_DOUT_ADDR) begin
                  data_output_buffer[g] <= dat_i[g];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // pin levels from buffers
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         serial_data_o <= `SIF_DOUT_RST;
         serial_clk_o <= `SIF_CKOUT_RST;
      end else if (ce_i) begin
         serial_data_o <= data_output_buffer;
         serial_clk_o <= clock_output_buffer;
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   assign rd_hit = 1'b1;
   always @* begin
      next_dat = 32'h00000000;
      case (adr_i)
         `SIF_NFEN_ADDR: next_dat = {24'h000000, rx_noise_filter_enable};
         `SIF_ISC_ADDR: next_dat = {24'h000000, input_switch_control};
         `SIF_PCG_ADDR: next_dat = {24'h000000, peripheral_clock_gate};
         `SIF_STAT_ADDR: next_dat[NCH-1:0] = channel_active_status;
         `SIF_OE_ADDR: next_dat[NCH-1:0] = serial_output_enable;
         `SIF_DOUT_ADDR: next_dat[NCH-1:0] = data_output_buffer;
         `SIF_CKOUT_ADDR: next_dat[NCH-1:0] = clock_output_buffer;
         // stop and start triggers read zero
         default: next_dat = 32'h00000000;
      endcase
   end

   // ----------------------------------------
   // wishbone answer: one wait cycle, ack one cycle
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else if (ce_i) begin
         ack_o <= cyc_i & stb_i & ~ack_o & rd_hit;
         dat_o <= next_dat;
      end
   end
endmodule // sif_top

// ==== sif_map.vh ====
// register offsets, field positions and reset values of the serial input filter block
`ifndef SIF_MAP_VH
`define SIF_MAP_VH
// ----------------------------------------
// register byte offsets (wishbone word aligned)
// ----------------------------------------
`define SIF_NFEN_IDX 20'hF0070
`define SIF_ADDR_W 22
`define SIF_NFEN_ADDR 22'h3C01C0
`define SIF_ISC_ADDR 22'h3C01C4
`define SIF_PCG_ADDR 22'h3C01C8
`define SIF_START_ADDR 22'h3C01CC
`define SIF_STOP_ADDR 22'h3C01D0
`define SIF_STAT_ADDR 22'h3C01D4
`define SIF_OE_ADDR 22'h3C01D8
`define SIF_DOUT_ADDR 22'h3C01DC
`define SIF_CKOUT_ADDR 22'h3C01E0
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SIF_FILT_ON_BIT 0
`define SIF_EXTINT_BIT 0
`define SIF_TIMER_BIT 1
`define SIF_CLK_ON_BIT 0
`define SIF_NFEN_RST 8'h00
`define SIF_ISC_RST 8'h00
`define SIF_PCG_RST 8'h00
`define SIF_STAT_RST 2'h0
`define SIF_OE_RST 2'h0
`define SIF_DOUT_RST 2'h3
`define SIF_CKOUT_RST 2'h3
`define SIF_FILT_HOLD 2
`endif

// ==== sif_rx_filter.v ====
// synchroniser and two-sample noise filter for the receive pin
module sif_rx_filter (
   // clock, reset, enable
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // control
   input wire filt_on_i,
   // pin in, conditioned out
   input wire rx_i,
   output wire rx_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   reg sync_a; // first stage, read only by sync_b
   reg sync_b; // synchronised level
   reg samp_prev; // previous synchronised sample
   reg filt; // accepted level

   // ----------------------------------------
   // synchroniser and filter
   // ----------------------------------------
   // idle line is high, so reset to 1 to avoid a false start edge
   always @(posedge clk_i) begin
      if (rst_i) begin
         sync_a <= 1'b1;
         sync_b <= 1'b1;
         samp_prev <= 1'b1;
         filt <= 1'b1;
      end else if (ce_i) begin
         sync_a <= rx_i;
         sync_b <= sync_a;
         samp_prev <= sync_b;
         // accept only after two equal samples, else hold
         if (sync_b == samp_prev) begin
            filt <= sync_b;
         end
         // disagreeing samples keep the old level
      end
   end

   // bypass gives the plain synchronised level
   assign rx_o = filt_on_i ? filt : sync_b;
endmodule // sif_rx_filter

// ==== sif_monitor.sv ====
// checker watching the sif_top ports
`include "sif_map.vh"
module sif_monitor #(parameter NCH = 2) (
   // clock, reset, bus
   input wire clk_i, input wire rst_i, input wire ce_i,
   input wire cyc_i, input wire stb_i, input wire we_i,
   input wire [21:0] adr_i, input wire [3:0] sel_i,
   input wire [31:0] dat_i, input wire ack_o,
   // receive path and channel view
   input wire async_receive_pin_i, input wire rx_data_o,
   input wire unit_clk_en_o, input wire [NCH-1:0] channel_run_o,
   input wire [NCH-1:0] port_release_o,
   input wire [NCH-1:0] serial_data_o, input wire [NCH-1:0] serial_clk_o
);
   // ----------------------------------------
   // one domain, so shared clock and reset
   // ----------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      cyc_i && stb_i && !ack_o && ce_i;
   endsequence
   sequence s_wr(a);
      s_take ##0 we_i && sel_i[0] && adr_i == a;
   endsequence
   property p_ack; s_take |=> ack_o; endproperty
   property p_ack1; ack_o |=> !ack_o; endproperty
   property p_stop; s_wr(`SIF_STOP_ADDR) ##0 dat_i[0] |=> !channel_run_o[0]; endproperty
   property p_clk; s_wr(`SIF_PCG_ADDR) |=> unit_clk_en_o == $past(dat_i[0]); endproperty
   property p_gate; !unit_clk_en_o |-> channel_run_o == 0; endproperty
   property p_excl; port_release_o[0] |-> !channel_run_o[0]; endproperty
   property p_rel; port_release_o[0] && ce_i |=> serial_data_o[0] && serial_clk_o[0]; endproperty
   // settle bound covers both filter settings
   property p_rx;
      ($stable(async_receive_pin_i) && ce_i) [*6] |-> rx_data_o == async_receive_pin_i;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack after request");
   a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
   a_stop: assert property (p_stop) else $error("stop left channel active");
   a_clk: assert property (p_clk) else $error("unit clock bit wrong");
   a_gate: assert property (p_gate) else $error("channel runs while gated");
   a_excl: assert property (p_excl) else $error("released while running");
   a_rel: assert property (p_rel) else $error("released pins not high");
   a_rx: assert property (p_rx) else $error("receive level not settled");
endmodule // sif_monitor

// ==== sif_rx_drv.sv ====
// far-side transmitter driving the receive line
module sif_rx_drv (input wire clk_i, output logic rxd_o);
   timeunit 1ns;
   timeprecision 1ns;
   initial rxd_o = 1'b1; // idle mark level
   // set a steady level after an edge
   task level(input logic v);
      @(posedge clk_i) rxd_o <= v;
   endtask
   // low pulse of n cycles, models noise or a start bit
   task pulse(input int n);
      @(posedge clk_i) rxd_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      rxd_o <= 1'b1;
   endtask
endmodule // sif_rx_drv

// ==== tb_top.sv ====
// testbench for sif_top with a receive-line partner
`include "sif_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [21:0] adr_i = 0;
   logic [3:0] sel_i = 0;
   logic [31:0] dat_i = 0, exp_q[$];
   logic ext_i = 0, tmr_i = 0, seen;
   logic [1:0] eng = 2'h3; // engines idle high
   wire [31:0] dat_o;
   wire ack_o, rxd, rx_data_o, extint_o, timer_in_o, unit_clk_en_o;
   wire [1:0] channel_run_o, port_release_o, serial_data_o, serial_clk_o;
   int n_fail = 0, check_count = 0, seed = 32'h8516aeea;
   always #25 clk_i = ~clk_i;
   // receive pin used as a plain input
   sif_rx_drv i_sif_rx_drv (.clk_i(clk_i), .rxd_o(rxd));
   sif_top i_sif_top (.*, .async_receive_pin_i(rxd), .external_interrupt_input_i(ext_i),
      .timer_ch1_input_pin_i(tmr_i), .engine_data_i(eng), .engine_clk_i(eng));
   task stop_test;
      $display("checks %0d errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task cmp(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // classic cycle, held until ack is sampled
   task wb(input logic w, input logic [21:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'h1};
      do @(posedge clk_i); while (ack_o !== 1'b1 && ++k < 20);
      {cyc_i, stb_i} <= 2'b00;
      if (k >= 20) begin
         n_fail++;
         stop_test;
      end
   endtask
   task rd(input logic [21:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(0, a, 0);
   endtask
   // read results are matched to the oldest note
   always @(posedge clk_i) if (ack_o === 1'b1 && !we_i) cmp(dat_o, exp_q.pop_front());
   task pulse_seen(input int n);
      fork
         i_sif_rx_drv.pulse(n);
         begin
            seen = 0;
            repeat (12) @(posedge clk_i) if (rx_data_o === 1'b0) seen = 1;
         end
      join
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      rd(`SIF_NFEN_ADDR, 0);
      rd(`SIF_ISC_ADDR, 0);
      rd(`SIF_DOUT_ADDR, 3);
      rd(`SIF_CKOUT_ADDR, 3);
      rd(22'h3C01FC, 0);
      wb(1, `SIF_DOUT_ADDR, 0); rd(`SIF_DOUT_ADDR, 3);
      wb(1, `SIF_START_ADDR, 1); rd(`SIF_STAT_ADDR, 0);
      wb(1, `SIF_NFEN_ADDR, $random(seed) | 1); rd(`SIF_NFEN_ADDR, 1);
      wb(1, `SIF_ISC_ADDR, 32'hFC); rd(`SIF_ISC_ADDR, 0);
      wb(1, `SIF_PCG_ADDR, 1); cmp(unit_clk_en_o, 1);
      wb(1, `SIF_START_ADDR, 3); wb(1, `SIF_STAT_ADDR, 0); rd(`SIF_STAT_ADDR, 3);
      wb(1, `SIF_CKOUT_ADDR, 0); rd(`SIF_CKOUT_ADDR, 3);
      wb(1, `SIF_STOP_ADDR, 1); rd(`SIF_STAT_ADDR, 2);
      rd(`SIF_STOP_ADDR, 0);
      wb(1, `SIF_CKOUT_ADDR, 0); wb(1, `SIF_DOUT_ADDR, 1); @(posedge clk_i) #1;
      cmp(serial_clk_o, 2);
      cmp(serial_data_o, 1);
      // channel 0 engine owns bit 0 (idle high), bit 1 takes the written 0
      wb(1, `SIF_OE_ADDR, 1); wb(1, `SIF_DOUT_ADDR, 0); rd(`SIF_DOUT_ADDR, 1);
      wb(1, `SIF_OE_ADDR, 0); wb(1, `SIF_CKOUT_ADDR, 3); wb(1, `SIF_DOUT_ADDR, 3);
      @(posedge clk_i) #1 cmp(port_release_o, 1);
      wb(1, `SIF_PCG_ADDR, 0); rd(`SIF_STAT_ADDR, 0);
      for (int i = 0; i < 4; i++) begin
         wb(1, `SIF_ISC_ADDR, i);
         ext_i <= 1'($random(seed));
         tmr_i <= 1'($random(seed));
         i_sif_rx_drv.level(1'($random(seed)));
         repeat (8) @(posedge clk_i);
         #1 cmp(extint_o, i[0] ? rxd : ext_i);
         cmp(timer_in_o, i[1] ? rxd : tmr_i);
      end
      i_sif_rx_drv.level(1);
      wb(1, `SIF_NFEN_ADDR, 0); pulse_seen(1); cmp(seen, 1);
      wb(1, `SIF_NFEN_ADDR, 1); pulse_seen(1); cmp(seen, 0);
      pulse_seen(4); cmp(seen, 1);
      stop_test;
   end
   // hang guard
   initial begin
      #2000000;
      n_fail++;
      stop_test;
   end
endmodule // tb_top
bind sif_top sif_monitor #(.NCH(NCH)) i_sif_monitor (.*);
